// ### logic/cep_regbank.sv
// Register bank of the contactless interface unit: access classes and error probe
//
// How it works
// - Read-write bits are CPU written and read; internal logic never alters them.
// - Dynamic bits take CPU writes; the command code reverts when execution completes, but a CPU command write in that same cycle wins.
// - Read-only bits show internal state; CPU writes leave them unchanged.
// - Write-only bits take CPU writes but always read back as zero.
// - Reserved and test locations are unimplemented: read zero, writes ignored.
// - Pin-select bit 7 set drives the secure clock on the shared pin.
// - Probe enable bit 3 puts the chosen error on aux outputs selecting 1010b.
// - Select codes 000..011 pick protocol, parity, checksum, collision errors.
// - Select codes 100..111 pick overflow, RF field, overheat, late write errors.
//
// Implementation choice: the strobed register port.
`include "cep_defs.svh"
`default_nettype none

module cep_regbank #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input  wire  logic              I_MCLK,
    input  wire  logic              I_RSTN,
    // Register port
    input  wire  logic [ADDR_W-1:0] I_ADDR,
    input  wire  logic [7:0]        I_WDATA,
    input  wire  logic              I_WR,
    input  wire  logic              I_RD,
    output var   logic [7:0]        O_RDATA,
    // Internal error flags and aux selection
    input  wire  logic [7:0]        I_ERR_FLAGS,
    input  wire  logic [3:0]        I_AUX1_SEL,
    input  wire  logic [3:0]        I_AUX2_SEL,
    output var   logic              O_ERROR_PROBE,
    output var   logic              O_AUX1,
    output var   logic              O_AUX2,
    // Command state machine link
    input  wire  logic              I_CMD_DONE,
    output var   logic [3:0]        O_CMD,
    output var   logic [7:0]        O_WO_CTRL,
    // Shared port pin
    input  wire  logic              I_SIC_CLK,
    input  wire  logic              I_PORT_OUT,
    input  wire  logic              I_PORT_OE,
    input  wire  logic              I_PIN_IN,
    output var   logic              O_PIN_OUT,
    output var   logic              O_PIN_OE,
    output var   logic              O_PORT_IN
);

    // Refuse address widths that cannot hold the offsets
    if (ADDR_W < 16) begin : g_bad_width
        $error("ADDR_W must be at least 16");
    end

    // Address decode shared by the write and read paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    cep_probe_if pif ();

    logic [7:0] cfg;
    logic [7:0] next_cfg;
    logic [3:0] cmd;
    logic [3:0] next_cmd;
    logic [7:0] wo_ctrl;
    logic [7:0] next_wo_ctrl;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       probe_q;
    logic       aux1_q;
    logic       aux2_q;
    logic       pin_out_q;
    logic       pin_oe_q;
    logic       sic_meta;
    logic       sic_sync;
    logic       pin_meta;
    logic       pin_sync;

    // Probe selector fed from the configuration fields
    assign pif.err = I_ERR_FLAGS;
    assign pif.sel = cep_pkg::cep_src_type'(cfg[`CEP_CFG_SEL_MSB:`CEP_CFG_SEL_LSB]);
    assign pif.en  = cfg[`CEP_CFG_EN_BIT];

    cep_probe_mux u_mux (
        .pif (pif.mux)
    );

    // Next values of the writable registers
    always_comb begin
        next_cfg     = cfg;
        next_cmd     = cmd;
        next_wo_ctrl = wo_ctrl;
        if (I_WR && hit(I_ADDR, `CEP_ADDR_CFG)) begin
            next_cfg = I_WDATA & `CEP_CFG_WMASK;
        end
        if (I_CMD_DONE) begin
            next_cmd = `CEP_CMD_IDLE;
        end
        if (I_WR && hit(I_ADDR, `CEP_ADDR_CMD)) begin
            next_cmd = I_WDATA[3:0];
        end
        if (I_WR && hit(I_ADDR, `CEP_ADDR_WO)) begin
            next_wo_ctrl = I_WDATA;
        end
    end

    // Register the control state
    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            cfg     <= `CEP_CFG_RST;
            cmd     <= `CEP_CMD_IDLE;
            wo_ctrl <= `CEP_WO_RST;
        end else begin
            cfg     <= next_cfg;
            cmd     <= next_cmd;
            wo_ctrl <= next_wo_ctrl;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_comb begin
        next_rdata = `CEP_RDATA_ZERO;
        if (I_RD) begin
            if (hit(I_ADDR, `CEP_ADDR_CFG)) begin
                next_rdata = cfg;
            end else if (hit(I_ADDR, `CEP_ADDR_CMD)) begin
                next_rdata = {4'h0, cmd};
            end else if (hit(I_ADDR, `CEP_ADDR_STAT)) begin
                next_rdata = I_ERR_FLAGS;
            end else if (hit(I_ADDR, `CEP_ADDR_WO)) begin
                next_rdata = `CEP_RDATA_ZERO;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            rdata <= `CEP_RDATA_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Synchronise the secure clock and the pin level into this domain
    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            sic_meta <= 1'b0;
            sic_sync <= 1'b0;
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            sic_meta <= I_SIC_CLK;
            sic_sync <= sic_meta;
            pin_meta <= I_PIN_IN;
            pin_sync <= pin_meta;
        end
    end

    // Output stage: pin multiplexer, probe bit and aux outputs
    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
            probe_q   <= 1'b0;
            aux1_q    <= 1'b0;
            aux2_q    <= 1'b0;
        end else begin
            if (cfg[`CEP_CFG_PIN_BIT]) begin
                pin_out_q <= sic_sync;
                pin_oe_q  <= 1'b1;
            end else begin
                pin_out_q <= I_PORT_OUT;
                pin_oe_q  <= I_PORT_OE;
            end
            probe_q <= pif.probe;
            aux1_q  <= (I_AUX1_SEL == `CEP_AUX_PROBE) && pif.probe;
            aux2_q  <= (I_AUX2_SEL == `CEP_AUX_PROBE) && pif.probe;
        end
    end

    assign O_RDATA       = rdata;
    assign O_CMD         = cmd;
    assign O_WO_CTRL     = wo_ctrl;
    assign O_ERROR_PROBE = probe_q;
    assign O_AUX1        = aux1_q;
    assign O_AUX2        = aux2_q;
    assign O_PIN_OUT     = pin_out_q;
    assign O_PIN_OE      = pin_oe_q;
    assign O_PORT_IN     = pin_sync;

    // Checks on the register behaviour and the probe path
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RSTN);

    property p_cfg_write;
        I_WR && hit(I_ADDR, `CEP_ADDR_CFG) |=> cfg == ($past(I_WDATA) & `CEP_CFG_WMASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not stored");

    property p_cfg_hold;
        !(I_WR && hit(I_ADDR, `CEP_ADDR_CFG)) |=> $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

    property p_cmd_revert;
        I_CMD_DONE && !(I_WR && hit(I_ADDR, `CEP_ADDR_CMD)) |=> O_CMD == `CEP_CMD_IDLE;
    endproperty
    a_cmd_revert: assert property (p_cmd_revert) else $error("command did not revert");

    property p_cmd_write;
        I_WR && hit(I_ADDR, `CEP_ADDR_CMD) |=> O_CMD == $past(I_WDATA[3:0]);
    endproperty
    a_cmd_write: assert property (p_cmd_write) else $error("command write lost");

    property p_stat_read;
        I_RD && hit(I_ADDR, `CEP_ADDR_STAT) |=> O_RDATA == $past(I_ERR_FLAGS);
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    property p_wo_read;
        I_RD && hit(I_ADDR, `CEP_ADDR_WO) |=> O_RDATA == `CEP_RDATA_ZERO;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");

    property p_test_read;
        I_RD && I_ADDR >= ADDR_W'(`CEP_ADDR_TEST_LO) && I_ADDR <= ADDR_W'(`CEP_ADDR_TEST_HI)
            |=> O_RDATA == `CEP_RDATA_ZERO;
    endproperty
    a_test_read: assert property (p_test_read) else $error("reserved read not zero");

    property p_pin_clock;
        cfg[`CEP_CFG_PIN_BIT] |=> O_PIN_OE && O_PIN_OUT == $past(sic_sync);
    endproperty
    a_pin_clock: assert property (p_pin_clock) else $error("secure clock not on pin");

    property p_pin_port;
        !cfg[`CEP_CFG_PIN_BIT] |=> O_PIN_OUT == $past(I_PORT_OUT) && O_PIN_OE == $past(I_PORT_OE);
    endproperty
    a_pin_port: assert property (p_pin_port) else $error("port pin not passed");

    property p_aux_probe;
        I_AUX1_SEL == `CEP_AUX_PROBE ##1 1'b1 |-> O_AUX1 == O_ERROR_PROBE;
    endproperty
    a_aux_probe: assert property (p_aux_probe) else $error("aux1 not carrying probe");

    property p_probe_sel;
        cfg[`CEP_CFG_EN_BIT] |=> O_ERROR_PROBE == $past(I_ERR_FLAGS[cfg[2:0]]);
    endproperty
    a_probe_sel: assert property (p_probe_sel) else $error("wrong error routed");

    property p_rsvd_zero;
        cfg[6:4] == 3'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved config bits set");

    property p_probe_off;
        !cfg[`CEP_CFG_EN_BIT] |=> !O_ERROR_PROBE && !O_AUX1 && !O_AUX2;
    endproperty
    a_probe_off: assert property (p_probe_off) else $error("probe not low when off");

    property p_aux2_probe;
        I_AUX2_SEL == `CEP_AUX_PROBE ##1 1'b1 |-> O_AUX2 == O_ERROR_PROBE;
    endproperty
    a_aux2_probe: assert property (p_aux2_probe) else $error("aux2 not carrying probe");

    property p_aux1_other;
        I_AUX1_SEL != `CEP_AUX_PROBE |=> !O_AUX1;
    endproperty
    a_aux1_other: assert property (p_aux1_other) else $error("aux1 high off code");

    property p_aux2_other;
        I_AUX2_SEL != `CEP_AUX_PROBE |=> !O_AUX2;
    endproperty
    a_aux2_other: assert property (p_aux2_other) else $error("aux2 high off code");

    property p_wo_write;
        I_WR && hit(I_ADDR, `CEP_ADDR_WO) |=> O_WO_CTRL == $past(I_WDATA);
    endproperty
    a_wo_write: assert property (p_wo_write) else $error("write-only value lost");

    property p_cmd_hold;
        !I_CMD_DONE && !(I_WR && hit(I_ADDR, `CEP_ADDR_CMD)) |=> $stable(O_CMD);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed unprompted");

    property p_cfg_read;
        I_RD && hit(I_ADDR, `CEP_ADDR_CFG) |=> O_RDATA == $past(cfg);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

    property p_rdata_idle;
        !I_RD |=> O_RDATA == `CEP_RDATA_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

    property p_port_in;
        I_RSTN |-> ##2 O_PORT_IN == $past(I_PIN_IN, 2);
    endproperty
    a_port_in: assert property (p_port_in) else $error("pin level not passed in");

endmodule

`default_nettype wire

// ### include/cep_defs.svh
// Register offsets, field positions, reset values and codes of the probe register bank
`ifndef CEP_DEFS_SVH
`define CEP_DEFS_SVH

// Register offsets (byte addresses on the 16-bit register port)
`define CEP_ADDR_CFG      16'h6330
`define CEP_ADDR_CMD      16'h6340
`define CEP_ADDR_STAT     16'h6341
`define CEP_ADDR_WO       16'h6342
`define CEP_ADDR_TEST_LO  16'h632c
`define CEP_ADDR_TEST_HI  16'h632e

// Configuration register fields
`define CEP_CFG_PIN_BIT   3'd7
`define CEP_CFG_EN_BIT    3'd3
`define CEP_CFG_SEL_MSB   3'd2
`define CEP_CFG_SEL_LSB   3'd0
`define CEP_CFG_WMASK     8'h8f
`define CEP_CFG_RST       8'h00

// Command, write-only and aux values
`define CEP_CMD_IDLE      4'h0
`define CEP_WO_RST        8'h00
`define CEP_AUX_PROBE     4'ha
`define CEP_RDATA_ZERO    8'h00

`endif

// ### include/cep_pkg.sv
// Types shared by the probe register bank modules
`default_nettype none

package cep_pkg;

    // Error source chosen by the probe-select field
    typedef enum logic [2:0] {
        CEP_SRC_PROTOCOL = 3'h0,
        CEP_SRC_PARITY   = 3'h1,
        CEP_SRC_CHECKSUM = 3'h2,
        CEP_SRC_COLLIDE  = 3'h3,
        CEP_SRC_OVERFLOW = 3'h4,
        CEP_SRC_RFFIELD  = 3'h5,
        CEP_SRC_OVERHEAT = 3'h6,
        CEP_SRC_LATEWR   = 3'h7
    } cep_src_type;

endpackage

`default_nettype wire

// ### include/cep_probe_if.sv
// Signals between the register bank and the error probe selector
`default_nettype none

interface cep_probe_if;
    logic [7:0]          err;
    cep_pkg::cep_src_type sel;
    logic                en;
    logic                probe;

    modport regs (output err, output sel, output en, input probe);
    modport mux  (input err, input sel, input en, output probe);
endinterface

`default_nettype wire

// ### logic/cep_probe_mux.sv
// Error probe selector: picks one error flag for the error bus bit
`default_nettype none

module cep_probe_mux (
    // Link to the register bank
    cep_probe_if.mux pif
);

    // Route the selected flag, held low while the probe is off
    always_comb begin
        pif.probe = 1'b0;
        if (pif.en) begin
            unique case (pif.sel)
                cep_pkg::CEP_SRC_PROTOCOL : pif.probe = pif.err[0];
                cep_pkg::CEP_SRC_PARITY   : pif.probe = pif.err[1];
                cep_pkg::CEP_SRC_CHECKSUM : pif.probe = pif.err[2];
                cep_pkg::CEP_SRC_COLLIDE  : pif.probe = pif.err[3];
                cep_pkg::CEP_SRC_OVERFLOW : pif.probe = pif.err[4];
                cep_pkg::CEP_SRC_RFFIELD  : pif.probe = pif.err[5];
                cep_pkg::CEP_SRC_OVERHEAT : pif.probe = pif.err[6];
                cep_pkg::CEP_SRC_LATEWR   : pif.probe = pif.err[7];
            endcase
        end
    end

endmodule

`default_nettype wire

// ### verif/cep_regbank_tb.sv
// Self-checking testbench of the probe register bank
`include "cep_defs.svh"
`default_nettype none

module cep_regbank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [7:0]  err_flags = 8'h00;
    logic [3:0]  aux1_sel = 4'h0;
    logic [3:0]  aux2_sel = 4'h0;
    logic        probe, aux1, aux2;
    logic        cmd_done = 1'b0;
    logic [3:0]  cmd;
    logic [7:0]  wo_ctrl;
    logic        sic_clk = 1'b0;
    logic        port_out = 1'b0;
    logic        port_oe = 1'b0;
    logic        pin_in = 1'b0;
    logic        pin_out, pin_oe, port_in;
    int          fails = 0;
    int          n_compared = 0;
    logic [7:0]  d;

    cep_regbank #(.ADDR_W(16)) dut (
        .I_MCLK(mclk), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_ERR_FLAGS(err_flags), .I_AUX1_SEL(aux1_sel),
        .I_AUX2_SEL(aux2_sel), .O_ERROR_PROBE(probe), .O_AUX1(aux1), .O_AUX2(aux2),
        .I_CMD_DONE(cmd_done), .O_CMD(cmd), .O_WO_CTRL(wo_ctrl), .I_SIC_CLK(sic_clk),
        .I_PORT_OUT(port_out), .I_PORT_OE(port_oe), .I_PIN_IN(pin_in),
        .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_PORT_IN(port_in)
    );

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Let n edges pass, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check({4'h0, cmd}, 8'h00);
        check(wo_ctrl, 8'h00);
        check({7'h0, pin_oe}, 8'h00);
        reg_rd(`CEP_ADDR_CFG, d);
        check(d, 8'h00);
        // Unused bits ignore writes; internal events leave control bits alone
        reg_wr(`CEP_ADDR_CFG, 8'h7f);
        @(posedge mclk);
        cmd_done <= 1'b1;
        @(posedge mclk);
        cmd_done <= 1'b0;
        reg_rd(`CEP_ADDR_CFG, d);
        check(d, 8'h0f);
        reg_wr(`CEP_ADDR_CFG, 8'h00);
        // Dynamic command written, then reverted by completion
        reg_wr(`CEP_ADDR_CMD, 8'h05);
        reg_rd(`CEP_ADDR_CMD, d);
        check(d, 8'h05);
        check({4'h0, cmd}, 8'h05);
        @(posedge mclk);
        cmd_done <= 1'b1;
        @(posedge mclk);
        cmd_done <= 1'b0;
        #1;
        check({4'h0, cmd}, 8'h00);
        reg_rd(`CEP_ADDR_CMD, d);
        check(d, 8'h00);
        // Status shows live flags and ignores writes
        @(posedge mclk);
        err_flags <= 8'ha5;
        reg_wr(`CEP_ADDR_STAT, 8'h5a);
        reg_rd(`CEP_ADDR_STAT, d);
        check(d, 8'ha5);
        // Write-only control reads back zero
        reg_wr(`CEP_ADDR_WO, 8'h3c);
        #1;
        check(wo_ctrl, 8'h3c);
        reg_rd(`CEP_ADDR_WO, d);
        check(d, 8'h00);
        // Test locations and an unmapped address
        for (int i = 0; i < 4; i++) begin
            reg_wr((i == 3) ? 16'h6000 : `CEP_ADDR_TEST_LO + 16'(i), 8'hff);
            reg_rd((i == 3) ? 16'h6000 : `CEP_ADDR_TEST_LO + 16'(i), d);
            check(d, 8'h00);
        end
        // Every probe select code, aux 1 routed to the probe, aux 2 elsewhere
        @(posedge mclk);
        aux1_sel <= `CEP_AUX_PROBE;
        aux2_sel <= 4'h5;
        for (int s = 0; s < 8; s++) begin
            reg_wr(`CEP_ADDR_CFG, 8'h08 | 8'(s));
            err_flags <= 8'h01 << s;
            tick(2);
            check({7'h0, probe}, 8'h01);
            check({6'h0, aux2, aux1}, 8'h01);
            @(posedge mclk);
            err_flags <= ~(8'h01 << s);
            tick(2);
            check({7'h0, probe}, 8'h00);
            check({7'h0, aux1}, 8'h00);
        end
        // Aux 2 now carries the probe, aux 1 elsewhere
        @(posedge mclk);
        aux1_sel <= 4'h5;
        aux2_sel <= `CEP_AUX_PROBE;
        err_flags <= 8'h80;
        tick(2);
        check({6'h0, aux2, aux1}, 8'h02);
        // Probe disabled holds the bit low
        reg_wr(`CEP_ADDR_CFG, 8'h07);
        err_flags <= 8'hff;
        tick(2);
        check({5'h0, aux2, aux1, probe}, 8'h00);
        // Secure clock on the shared pin, three edges late
        reg_wr(`CEP_ADDR_CFG, 8'h80);
        sic_clk <= 1'b1;
        tick(3);
        check({6'h0, pin_oe, pin_out}, 8'h03);
        @(posedge mclk);
        sic_clk <= 1'b0;
        tick(2);
        check({7'h0, pin_out}, 8'h01);
        tick(1);
        check({7'h0, pin_out}, 8'h00);
        // Ordinary port mode
        reg_wr(`CEP_ADDR_CFG, 8'h00);
        sic_clk <= 1'b1;
        port_out <= 1'b1;
        port_oe <= 1'b0;
        pin_in <= 1'b1;
        tick(2);
        check({5'h0, port_in, pin_oe, pin_out}, 8'h05);
        @(posedge mclk);
        port_out <= 1'b0;
        port_oe <= 1'b1;
        tick(1);
        check({6'h0, pin_oe, pin_out}, 8'h02);
        // Reset in mid-run clears every configuration field
        reg_wr(`CEP_ADDR_CFG, 8'h8b);
        reg_rd(`CEP_ADDR_CFG, d);
        check(d, 8'h8b);
        @(posedge mclk);
        rst_n <= 1'b0;
        port_oe <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check({6'h0, pin_oe, probe}, 8'h00);
        reg_rd(`CEP_ADDR_CFG, d);
        check(d, 8'h00);
        end_of_test();
    end
endmodule

`default_nettype wire
